// [shared/pps_pkg.sv]
package pps_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] ADDR_STEER = 4'h0;
  localparam logic [3:0] ADDR_MODE = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [7:0] STEER_RESET = 8'h01;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] STEER_WMASK = 8'h1F;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SYNC_BIT = 4;
  localparam int PIN_LO = 0;
  localparam int PIN_HI = 3;
  localparam int POL_LO = 0;
  localparam int POL_HI = 1;
  localparam int PWMSEL_LO = 2;
  localparam int PWMSEL_HI = 3;
  localparam int OCFG_LO = 6;
  localparam int OCFG_HI = 7;
  localparam logic [1:0] PWMSEL_PWM = 2'h3;
  localparam logic [1:0] OCFG_SINGLE = 2'h0;
  localparam int NPINS = 4;

  // ****************************************
  // Bus answers
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PPS_IDLE = 2'h0,
    PPS_RESP = 2'h1
  } pps_bus_e;

endpackage

// [rtl/pps_steering.sv]
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
// Function
// - With sync bit set, steering changes wait for the next PWM period start.
// - With sync bit clear, a steering write takes effect at once.
// - Bits 3..0 route the polarity-adjusted PWM to pins D..A; clear gives port control.
// - Steering active only when mode bits 3:2 are 11 and output config is 00.
// - Steering register bits 7..5 read zero and ignore writes.
// - Mode bit 0 selects the polarity of steered pins A and C, bit 1 that of steered pins B and D.
// - Shutdown forces shutdown state only on steered pins.
module pps_steering (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic PWM_WAVE,
  input wire logic PERIOD_START,
  input wire logic SHUTDOWN_ACTIVE,
  input wire logic [3:0] SHUTDOWN_LEVEL,
  input wire logic [3:0] SHUTDOWN_TRISTATE,
  input wire logic [3:0] PORT_OUT,
  input wire logic [3:0] PORT_OE,
  output logic [3:0] PIN_OUT,
  output logic [3:0] PIN_OE,
  output logic [3:0] STEER_ACTIVE
);
  import pps_pkg::*;

  // ****************************************
  // Helper functions
  // ****************************************
  // Applies the pair polarity bit to the raw waveform; a set bit inverts it.
  function automatic logic pol_apply(input logic wave, input logic invert);
    pol_apply = wave ^ invert;
  endfunction

  // True for the three offsets that hold a register.
  function automatic logic addr_known(input logic [3:0] addr);
    addr_known = (addr == ADDR_STEER) || (addr == ADDR_MODE) || (addr == ADDR_STATUS);
  endfunction

  // Level of one pin: port control, the shutdown level or the steered waveform.
  function automatic logic pin_level_sel(
    input logic steered,
    input logic port_level,
    input logic shut,
    input logic shut_level,
    input logic wave
  );
    if (!steered) begin
      pin_level_sel = port_level;
    end else if (shut) begin
      pin_level_sel = shut_level;
    end else begin
      pin_level_sel = wave;
    end
  endfunction

  // Drive enable of one pin: a steered pin drives unless shutdown releases it.
  function automatic logic pin_enable_sel(
    input logic steered,
    input logic port_enable,
    input logic shut,
    input logic shut_release
  );
    if (!steered) begin
      pin_enable_sel = port_enable;
    end else begin
      pin_enable_sel = !(shut && shut_release);
    end
  endfunction

  // ****************************************
  // Bus slave
  // ****************************************
  pps_bus_e wst_r;
  pps_bus_e rst_r;
  pps_bus_e wst_nxt;
  logic aw_got_r;
  logic w_got_r;
  logic [3:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wstrb0_r;
  logic [1:0] bresp_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [7:0] steer_ctrl_r;
  logic [7:0] mode_ctrl_r;
  logic [3:0] active_r;
  logic [3:0] pin_out_r;
  logic [3:0] pin_oe_r;

  wire aw_take = S_AXI_AWVALID && !aw_got_r && (wst_r == PPS_IDLE);
  wire w_take = S_AXI_WVALID && !w_got_r && (wst_r == PPS_IDLE);
  wire aw_have = aw_got_r || aw_take;
  wire w_have = w_got_r || w_take;
  // A half that arrived alone stays parked until the write fires with both halves.
  wire aw_got_nxt = !wr_fire && aw_have;
  wire w_got_nxt = !wr_fire && w_have;
  wire [3:0] wr_addr = aw_got_r ? awaddr_r : S_AXI_AWADDR;
  wire [7:0] wr_data = w_got_r ? wdata_r : S_AXI_WDATA[7:0];
  wire wr_lane0 = w_got_r ? wstrb0_r : S_AXI_WSTRB[0];
  wire wr_fire = (wst_r == PPS_IDLE) && aw_have && w_have;
  wire wr_steer = wr_fire && wr_lane0 && (wr_addr == ADDR_STEER);
  wire wr_mode = wr_fire && wr_lane0 && (wr_addr == ADDR_MODE);
  wire wr_known = addr_known(wr_addr);
  wire rd_take = S_AXI_ARVALID && (rst_r == PPS_IDLE);

  assign S_AXI_AWREADY = (wst_r == PPS_IDLE) && !aw_got_r;
  assign S_AXI_WREADY = (wst_r == PPS_IDLE) && !w_got_r;
  assign S_AXI_BVALID = (wst_r == PPS_RESP);
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = (rst_r == PPS_IDLE);
  assign S_AXI_RVALID = (rst_r == PPS_RESP);
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  // ****************************************
  // Steering decode
  // ****************************************
  wire [7:0] steer_wr_val = wr_data & STEER_WMASK;
  wire steer_mode_on = (mode_ctrl_r[PWMSEL_HI:PWMSEL_LO] == PWMSEL_PWM)
    && (mode_ctrl_r[OCFG_HI:OCFG_LO] == OCFG_SINGLE);
  wire pol_lo_active = mode_ctrl_r[POL_LO];
  wire pol_hi_active = mode_ctrl_r[POL_HI];
  wire [3:0] pending = steer_ctrl_r[PIN_HI:PIN_LO];
  wire sync_on = steer_ctrl_r[SYNC_BIT];
  wire [3:0] wave_pol;
  wire [3:0] sel = steer_mode_on ? active_r : 4'h0;
  wire [3:0] pin_out_nxt;
  wire [3:0] pin_oe_nxt;
  wire [3:0] active_nxt;

  // Pins A and C are the high-side pair, B and D the low-side pair.
  assign wave_pol[0] = pol_apply(PWM_WAVE, pol_lo_active);
  assign wave_pol[2] = pol_apply(PWM_WAVE, pol_lo_active);
  assign wave_pol[1] = pol_apply(PWM_WAVE, pol_hi_active);
  assign wave_pol[3] = pol_apply(PWM_WAVE, pol_hi_active);

  // Immediate mode follows the write; sync mode loads the pending copy at period start.
  assign active_nxt = (wr_steer && !steer_wr_val[SYNC_BIT]) ? steer_wr_val[PIN_HI:PIN_LO]
    : (sync_on && PERIOD_START) ? pending
    : (!sync_on) ? pending
    : active_r;

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      // Only steered pins see the shutdown override; port pins pass through untouched.
      assign pin_out_nxt[gi] = pin_level_sel(sel[gi], PORT_OUT[gi], SHUTDOWN_ACTIVE,
        SHUTDOWN_LEVEL[gi], wave_pol[gi]);
      assign pin_oe_nxt[gi] = pin_enable_sel(sel[gi], PORT_OE[gi], SHUTDOWN_ACTIVE,
        SHUTDOWN_TRISTATE[gi]);
    end
  endgenerate

  assign PIN_OUT = pin_out_r;
  assign PIN_OE = pin_oe_r;
  assign STEER_ACTIVE = sel;

  // ****************************************
  // Write channel
  // ****************************************
  always_comb begin
    wst_nxt = wst_r;
    if (wr_fire) begin
      wst_nxt = PPS_RESP;
    end else if (wst_r == PPS_RESP && S_AXI_BREADY) begin
      wst_nxt = PPS_IDLE;
    end
  end

  // Address and data may arrive in either order; each is held until its partner shows up.
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      awaddr_r <= 4'h0;
    end else if (aw_take) begin
      awaddr_r <= S_AXI_AWADDR;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      wdata_r <= 8'h00;
      wstrb0_r <= 1'h0;
    end else if (w_take) begin
      wdata_r <= S_AXI_WDATA[7:0];
      wstrb0_r <= S_AXI_WSTRB[0];
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      aw_got_r <= 1'h0;
      w_got_r <= 1'h0;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      wst_r <= PPS_IDLE;
    end else begin
      wst_r <= wst_nxt;
    end
  end

  // The response code is latched with the write so that it stands for the whole answer.
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bresp_r <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rst_r <= PPS_IDLE;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (rd_take) begin
      rst_r <= PPS_RESP;
      rresp_r <= addr_known(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      case (S_AXI_ARADDR)
        ADDR_STEER: begin
          rdata_r <= {24'h00_0000, steer_ctrl_r};
        end
        ADDR_MODE: begin
          rdata_r <= {24'h00_0000, mode_ctrl_r};
        end
        ADDR_STATUS: begin
          rdata_r <= {27'h000_0000, steer_mode_on, sel};
        end
        default: begin
          rdata_r <= 32'h0000_0000;
        end
      endcase
    end else if (rst_r == PPS_RESP && S_AXI_RREADY) begin
      rst_r <= PPS_IDLE;
    end
  end

  // ****************************************
  // Control registers and pins
  // ****************************************
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      steer_ctrl_r <= STEER_RESET;
    end else if (wr_steer) begin
      steer_ctrl_r <= steer_wr_val;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      mode_ctrl_r <= MODE_RESET;
    end else if (wr_mode) begin
      mode_ctrl_r <= wr_data;
    end
  end

  // The active mask is what the pins obey; with sync set it waits for a period start to load the register copy.
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      active_r <= STEER_RESET[PIN_HI:PIN_LO];
    end else begin
      active_r <= active_nxt;
    end
  end

  // Pins are registered so that a glitch in the selection never reaches the drivers.
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      pin_out_r <= 4'h0;
      pin_oe_r <= 4'h0;
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

endmodule

// [verification/pps_props.sv]
`timescale 1ns/10ps
module pps_props
  import pps_pkg::*;
(
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic SHUTDOWN_ACTIVE,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic [3:0] SHUTDOWN_LEVEL,
  input wire logic [3:0] SHUTDOWN_TRISTATE,
  input wire logic [3:0] PORT_OUT,
  input wire logic [3:0] PORT_OE,
  input wire logic [3:0] PIN_OUT,
  input wire logic [3:0] PIN_OE,
  input wire logic [3:0] STEER_ACTIVE,
  input wire logic [31:0] S_AXI_RDATA
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  sequence s_rd_steer; S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == ADDR_STEER; endsequence
  property p_pout; NRST |=> ((PIN_OUT ^ $past(PORT_OUT)) & ~$past(STEER_ACTIVE)) == 4'h0; endproperty
  a_pout: assert property (p_pout) else $error("port pin level wrong");
  property p_poe; NRST |=> ((PIN_OE ^ $past(PORT_OE)) & ~$past(STEER_ACTIVE)) == 4'h0; endproperty
  a_poe: assert property (p_poe) else $error("port pin enable wrong");
  property p_son; !SHUTDOWN_ACTIVE |=> (PIN_OE & $past(STEER_ACTIVE)) == $past(STEER_ACTIVE);
  endproperty
  a_son: assert property (p_son) else $error("steered pin not driven");
  property p_sdoe; SHUTDOWN_ACTIVE |=>
    ((PIN_OE ^ ~$past(SHUTDOWN_TRISTATE)) & $past(STEER_ACTIVE)) == 4'h0; endproperty
  a_sdoe: assert property (p_sdoe) else $error("shutdown enable wrong");
  property p_sdlv; SHUTDOWN_ACTIVE |=>
    ((PIN_OUT ^ $past(SHUTDOWN_LEVEL)) & $past(STEER_ACTIVE & ~SHUTDOWN_TRISTATE)) == 4'h0;
  endproperty
  a_sdlv: assert property (p_sdlv) else $error("shutdown level wrong");
  property p_ac; !SHUTDOWN_ACTIVE && STEER_ACTIVE[0] && STEER_ACTIVE[2] |=>
    PIN_OUT[0] == PIN_OUT[2]; endproperty
  a_ac: assert property (p_ac) else $error("pins A and C differ");
  property p_bd; !SHUTDOWN_ACTIVE && STEER_ACTIVE[1] && STEER_ACTIVE[3] |=>
    PIN_OUT[1] == PIN_OUT[3]; endproperty
  a_bd: assert property (p_bd) else $error("pins B and D differ");
  property p_rd; s_rd_steer |=> S_AXI_RVALID && S_AXI_RDATA[31:5] == 27'h0; endproperty
  a_rd: assert property (p_rd) else $error("steering upper bits not zero");
endmodule
bind pps_steering pps_props chk_u (.*);

// [verification/pps_drv.sv]
`timescale 1ns/10ps
module pps_drv (
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  output logic [3:0] pin_level
);
  // A released pin is pulled low by the gate driver input.
  assign pin_level = pin_out & pin_oe;
endmodule

// [verification/tb_top.sv]
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top;
  import pps_pkg::*;
  logic CLOCK, NRST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic PWM_WAVE, PERIOD_START, SHUTDOWN_ACTIVE, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_ARREADY, S_AXI_RVALID;
  logic [3:0] S_AXI_AWADDR, S_AXI_WSTRB, S_AXI_ARADDR, SHUTDOWN_LEVEL, SHUTDOWN_TRISTATE;
  logic [3:0] PORT_OUT, PORT_OE, PIN_OUT, PIN_OE, STEER_ACTIVE, pin_level, ex;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd_d;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rd_r, wr_b;
  int n_errors = 0;
  int n_checks = 0;
  // Each row is mode byte, steering byte, expected active mask.
  logic [19:0] rows [6] = '{20'h0C0FF, 20'h0C055, 20'h080A0, 20'h4C0A0, 20'h0F0AA, 20'h0D088};
  pps_steering dut_u (.*);
  pps_drv drv_u (.pin_out(PIN_OUT), .pin_oe(PIN_OE), .pin_level(pin_level));
  initial begin
    CLOCK = 1'h0;
    forever #4 CLOCK = ~CLOCK;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic pa;
    logic pw;
    pa = 1'h1;
    pw = 1'h1;
    @(posedge CLOCK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h0, d};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    while (pa || pw) begin
      @(negedge CLOCK);
      pa = pa && !S_AXI_AWREADY;
      pw = pw && !S_AXI_WREADY;
      @(posedge CLOCK);
      {S_AXI_AWVALID, S_AXI_WVALID} <= {pa, pw};
    end
    do @(negedge CLOCK); while (!S_AXI_BVALID);
    wr_b = S_AXI_BRESP;
    @(posedge CLOCK);
    S_AXI_BREADY <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge CLOCK);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    do @(negedge CLOCK); while (!S_AXI_ARREADY);
    @(posedge CLOCK);
    S_AXI_ARVALID <= 1'h0;
    do @(negedge CLOCK); while (!S_AXI_RVALID);
    rd_d = S_AXI_RDATA;
    rd_r = S_AXI_RRESP;
    @(posedge CLOCK);
    S_AXI_RREADY <= 1'h0;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // The whole sequence needs well under a thousand cycles.
  initial begin
    #200000;
    n_errors++;
    test_done();
  end
  initial begin
    {NRST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 6'h0;
    {PWM_WAVE, PERIOD_START, SHUTDOWN_ACTIVE, S_AXI_AWADDR, S_AXI_ARADDR} = 11'h0;
    {S_AXI_WDATA, S_AXI_WSTRB, SHUTDOWN_LEVEL, SHUTDOWN_TRISTATE} = {32'h0, 12'hF52};
    {PORT_OUT, PORT_OE} = 8'h63;
    repeat (4) @(posedge CLOCK);
    NRST <= 1'h1;
    foreach (rows[i]) begin
      wr(ADDR_MODE, rows[i][19:12]);
      wr(ADDR_STEER, rows[i][11:4]);
      PWM_WAVE <= i[0];
      repeat (2) @(negedge CLOCK);
      ex = (rows[i][3:0] & ({4{i[0]}} ^ {2{rows[i][13:12]}})) | (~rows[i][3:0] & 4'h2);
      `CHK("active", rows[i][3:0], STEER_ACTIVE)
      `CHK("pins", ex, pin_level)
      $display("row %0d done", i);
    end
    wr(ADDR_STEER, 8'hE3);
    `CHK("immediate", 4'h3, STEER_ACTIVE)
    `CHK("wr okay", RESP_OKAY, wr_b)
    rd(ADDR_STEER);
    `CHK("upper", 32'h03, rd_d)
    rd(ADDR_STATUS);
    `CHK("status", 32'h13, rd_d)
    S_AXI_WSTRB <= 4'h0;
    wr(ADDR_STEER, 8'h00);
    S_AXI_WSTRB <= 4'hF;
    `CHK("no lane", 4'h3, STEER_ACTIVE)
    wr(ADDR_STEER, 8'h1C);
    repeat (3) @(negedge CLOCK);
    `CHK("held", 4'h3, STEER_ACTIVE)
    @(posedge CLOCK);
    PERIOD_START <= 1'h1;
    @(posedge CLOCK);
    PERIOD_START <= 1'h0;
    SHUTDOWN_ACTIVE <= 1'h1;
    @(negedge CLOCK);
    `CHK("loaded", 4'hC, STEER_ACTIVE)
    @(negedge CLOCK);
    `CHK("shutdown", 4'h6, pin_level)
    $display("sync and shutdown done");
    @(posedge CLOCK);
    SHUTDOWN_ACTIVE <= 1'h0;
    rd(4'hC);
    `CHK("unmapped", RESP_SLVERR, rd_r)
    `CHK("unmapped data", 32'h0, rd_d)
    wr(4'hC, 8'h1F);
    `CHK("wr unmapped", RESP_SLVERR, wr_b)
    NRST <= 1'h0;
    repeat (4) @(negedge CLOCK);
    `CHK("rst active", 4'h0, STEER_ACTIVE)
    `CHK("rst pins", 4'h0, PIN_OE)
    @(posedge CLOCK);
    NRST <= 1'h1;
    rd(ADDR_STEER);
    `CHK("rst steer", 32'h01, rd_d)
    rd(ADDR_MODE);
    `CHK("rst mode", 32'h00, rd_d)
    $display("reset done");
    test_done();
  end
endmodule
